/* core/fsoc_failsafe_output_control.sv */
`timescale 1ns/10ps
`default_nettype none
module fsoc_failsafe_output_control
  import fsoc_pkg::*;
#(
  parameter int unsigned PWM_PERIOD_CYC = 32'(FSOC_PWM_PERIOD_CYC),
  parameter int unsigned PWM_HIGH_CYC   = 32'(FSOC_PWM_HIGH_CYC),
  parameter int unsigned SQ_HALF_CYC    = 32'(FSOC_SQ_HALF_CYC)
) (
  input  wire logic       clk,                  // 250 MHz clock
  input  wire logic       system_reset_out_n,                 // async reset, active low
  input  wire logic       reg_wr_en,            // spi register write strobe
  input  wire logic       reg_rd_en,            // spi register read strobe
  input  wire logic [6:0] reg_addr,             // spi register address
  input  wire logic [7:0] reg_wdata,            // spi write data
  output logic      [7:0] reg_rdata,            // read data, next cycle
  input  wire fsoc_mode_t sbc_mode,             // mode from mode control
  input  wire logic       sys_reset_evt,        // pulse: reset mode entry
  input  wire logic       bat_smps_uv,          // smps battery undervoltage
  input  wire logic       bat_uv,               // battery monitor undervolt
  input  wire logic       bat_ov,               // battery monitor overvolt
  input  wire logic       timer2_out,           // timer 2 output level
  input  wire logic       ot_activate,          // overtemp activation flag
  input  wire logic       ot_release,           // overtemp release flag
  input  wire logic       ot_warning,           // overtemp warning flag
  input  wire logic       otw_irq_enable,       // warning irq enable
  input  wire logic [2:0] limp_pin_cfg,         // nv config pins 4,3,2
  output logic            aux_out_o,            // aux output level
  output logic            aux_out_oe,           // aux output enable
  output logic            fallback_out_o,       // fallback pin level
  output logic            fallback_out_oe,      // fallback pin pull-down
  output logic            system_reset_out_n_o, // reset pin level
  output logic            system_reset_out_n_oe,// reset pin pull-down
  output logic            highvolt_pin_2,       // pin 2 high-side on
  output logic            highvolt_pin_3,       // pin 3 high-side on
  output logic            highvolt_pin_4,       // pin 4 high-side on
  output logic            highvolt_failsafe,    // hv pins fail-safe state
  output logic            supplies_off,         // converter/xcvr/regs off
  output logic            overload_active,      // overload mode flag
  output logic            protect_active,       // failsafe_protect_mode
  output logic            reset_mode_req,       // pulse: go through reset
  output logic            overheat_warning_irq  // pulse: warning irq
);

  fsoc_ctrl_t  ctrl_reg;
  fsoc_state_t state_reg;
  fsoc_state_t state_next;
  logic [2:0]  lh_cfg_reg;
  logic        cfg_loaded_reg;
  logic [31:0] pwm_cnt_reg;
  logic [31:0] sq_cnt_reg;
  logic        sq_level_reg;
  logic        off_seen_reg;
  logic        warn_seen_reg;
  logic        aux_level_reg;
  logic        wr_hit;
  logic        off_entry;
  logic        rcc_full_reset;
  logic        enter_overload;
  logic        enter_protect;
  logic        aux_shutdown;
  logic        aux_source;
  logic        limp_on;

  assign wr_hit    = reg_wr_en && (reg_addr == FSOC_FAILSAFE_CONTROL_ADDR);
  assign off_entry = (sbc_mode == FSOC_MODE_OFF) && !off_seen_reg;
  assign limp_on   = ctrl_reg.fallback_request;

  // reset into reset mode with the counter full is a serious failure
  assign rcc_full_reset = sys_reset_evt && (state_reg == FSOC_ST_RUN) &&
                          (ctrl_reg.reset_event_counter == FSOC_RCC_MAX);
  assign enter_overload = ot_activate && (state_reg != FSOC_ST_OVERLOAD);
  assign enter_protect  = rcc_full_reset && !ot_activate;

  // supervisor: overload has priority over protect mode
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      FSOC_ST_RUN: begin
        if (ot_activate) begin
          state_next = FSOC_ST_OVERLOAD;
        end else if (rcc_full_reset) begin
          state_next = FSOC_ST_PROTECT;
        end
      end
      FSOC_ST_OVERLOAD: begin
        if (ot_release) begin
          state_next = FSOC_ST_RELEASE;
        end
      end
      FSOC_ST_RELEASE: begin
        state_next = ot_activate ? FSOC_ST_OVERLOAD : FSOC_ST_RUN;
      end
      FSOC_ST_PROTECT: begin
        if (ot_activate) begin
          state_next = FSOC_ST_OVERLOAD;
        end else if (sbc_mode == FSOC_MODE_OFF) begin
          state_next = FSOC_ST_RUN;
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge system_reset_out_n) begin
    if (!system_reset_out_n) begin
      state_reg <= FSOC_ST_RUN;
    end else begin
      state_reg <= state_next;
    end
  end

  // off-mode edge detector, so off entry clears the bit only once
  always_ff @(posedge clk or negedge system_reset_out_n) begin
    if (!system_reset_out_n) begin
      off_seen_reg <= 1'b0;
    end else begin
      off_seen_reg <= (sbc_mode == FSOC_MODE_OFF);
    end
  end

  // control register; hardware events win over a same-cycle spi write
  always_ff @(posedge clk or negedge system_reset_out_n) begin
    if (!system_reset_out_n) begin
      ctrl_reg <= FSOC_FAILSAFE_CONTROL_RST;
    end else begin
      if (wr_hit) begin
        ctrl_reg <= fsoc_ctrl_t'(reg_wdata);
      end
      if (sys_reset_evt && !bat_smps_uv &&
          ctrl_reg.reset_event_counter != FSOC_RCC_MAX) begin
        ctrl_reg.reset_event_counter <=
          ctrl_reg.reset_event_counter + 2'h1;
      end
      if (off_entry) begin
        ctrl_reg.fallback_request <= 1'b0;
      end
      if (enter_overload || enter_protect) begin
        ctrl_reg.fallback_request <= 1'b1;
      end
    end
  end

  // register read data is registered; unmapped addresses read zero
  always_ff @(posedge clk or negedge system_reset_out_n) begin
    if (!system_reset_out_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd_en) begin
      reg_rdata <= (reg_addr == FSOC_FAILSAFE_CONTROL_ADDR) ?
                   8'(ctrl_reg) : 8'h00;
    end
  end

  // limp pin selection is caught once, the cycle after reset release
  always_ff @(posedge clk or negedge system_reset_out_n) begin
    if (!system_reset_out_n) begin
      lh_cfg_reg     <= 3'h0;
      cfg_loaded_reg <= 1'b0;
    end else if (!cfg_loaded_reg) begin
      lh_cfg_reg     <= limp_pin_cfg;
      cfg_loaded_reg <= 1'b1;
    end
  end

  // aux level: shutdown overrides the source select in normal mode while the supervisor is in the run state
  always_comb begin
    aux_shutdown = (sbc_mode == FSOC_MODE_NORMAL) &&
                   state_reg == FSOC_ST_RUN &&
                   ((ctrl_reg.aux_out_battery_shutdown[0] && bat_uv) ||
                    (ctrl_reg.aux_out_battery_shutdown[1] && bat_ov));
    unique case (ctrl_reg.aux_out_source_select)
      FSOC_SRC_LOW:    aux_source = 1'b0;
      FSOC_SRC_ACTIVE: aux_source = state_reg == FSOC_ST_RUN &&
                         (sbc_mode == FSOC_MODE_NORMAL ||
                          sbc_mode == FSOC_MODE_RESET ||
                          sbc_mode == FSOC_MODE_STANDBY);
      FSOC_SRC_NORMAL: aux_source = state_reg == FSOC_ST_RUN &&
                         sbc_mode == FSOC_MODE_NORMAL;
      FSOC_SRC_TIMER:  aux_source = timer2_out;
    endcase
  end

  always_ff @(posedge clk or negedge system_reset_out_n) begin
    if (!system_reset_out_n) begin
      aux_level_reg <= 1'b0;
    end else begin
      aux_level_reg <= aux_source && !aux_shutdown;
    end
  end

  // open-drain keeps the same logic but never drives high
  assign aux_out_o  = ctrl_reg.aux_out_drive_select ? 1'b0 : aux_level_reg;
  assign aux_out_oe = ctrl_reg.aux_out_drive_select ?
                      !aux_level_reg : 1'b1;

  // fallback pin follows the bit directly so clearing releases at once
  assign fallback_out_o  = 1'b0;
  assign fallback_out_oe = ctrl_reg.fallback_request;

  // reset pin held low through overload and the release step
  assign system_reset_out_n_o  = 1'b0;
  assign system_reset_out_n_oe = (state_reg == FSOC_ST_OVERLOAD) ||
                                 (state_reg == FSOC_ST_RELEASE);
  assign overload_active   = (state_reg == FSOC_ST_OVERLOAD);
  assign supplies_off      = (state_reg == FSOC_ST_OVERLOAD);
  assign highvolt_failsafe = (state_reg == FSOC_ST_OVERLOAD);
  assign protect_active    = (state_reg == FSOC_ST_PROTECT);
  assign reset_mode_req    = (state_reg == FSOC_ST_RELEASE);

  // limp waveform counters run only while limp home is active,
  // so each activation starts with a fresh high phase
  always_ff @(posedge clk or negedge system_reset_out_n) begin
    if (!system_reset_out_n) begin
      pwm_cnt_reg <= 32'h0000_0000;
    end else if (!limp_on || pwm_cnt_reg == PWM_PERIOD_CYC - 1) begin
      pwm_cnt_reg <= 32'h0000_0000;
    end else begin
      pwm_cnt_reg <= pwm_cnt_reg + 32'h0000_0001;
    end
  end

  always_ff @(posedge clk or negedge system_reset_out_n) begin
    if (!system_reset_out_n) begin
      sq_cnt_reg   <= 32'h0000_0000;
      sq_level_reg <= 1'b1;
    end else if (!limp_on) begin
      sq_cnt_reg   <= 32'h0000_0000;
      sq_level_reg <= 1'b1;
    end else if (sq_cnt_reg == SQ_HALF_CYC - 1) begin
      sq_cnt_reg   <= 32'h0000_0000;
      sq_level_reg <= !sq_level_reg;
    end else begin
      sq_cnt_reg <= sq_cnt_reg + 32'h0000_0001;
    end
  end

  // high-side drivers, registered to keep the pins glitch free
  always_ff @(posedge clk or negedge system_reset_out_n) begin
    if (!system_reset_out_n) begin
      highvolt_pin_2 <= 1'b0;
      highvolt_pin_3 <= 1'b0;
      highvolt_pin_4 <= 1'b0;
    end else begin
      highvolt_pin_2 <= lh_cfg_reg[0] && limp_on;
      highvolt_pin_3 <= lh_cfg_reg[1] && limp_on &&
                        (pwm_cnt_reg < PWM_HIGH_CYC);
      highvolt_pin_4 <= lh_cfg_reg[2] && limp_on && sq_level_reg;
    end
  end

  // warning interrupt is one pulse per rising warning flag
  always_ff @(posedge clk or negedge system_reset_out_n) begin
    if (!system_reset_out_n) begin
      warn_seen_reg        <= 1'b0;
      overheat_warning_irq <= 1'b0;
    end else begin
      warn_seen_reg        <= ot_warning;
      overheat_warning_irq <= ot_warning && !warn_seen_reg &&
                              otw_irq_enable;
    end
  end

  aux_od_float_a: assert property (@(posedge clk) disable iff (!system_reset_out_n)
    ctrl_reg.aux_out_drive_select && aux_level_reg |-> !aux_out_oe)
    else $error("aux driven while open-drain high");
  aux_shutdown_a: assert property (@(posedge clk) disable iff (!system_reset_out_n)
    aux_shutdown |=> !aux_level_reg)
    else $error("aux not forced low on battery fault");
  aux_src_low_a: assert property (@(posedge clk) disable iff (!system_reset_out_n)
    ctrl_reg.aux_out_source_select == FSOC_SRC_LOW &&
    $stable(ctrl_reg) |=> !aux_level_reg)
    else $error("aux high with source low");
  fallback_pin_a: assert property (@(posedge clk) disable iff (!system_reset_out_n)
    fallback_out_oe == ctrl_reg.fallback_request && !fallback_out_o)
    else $error("fallback pin mismatch");
  fallback_set_a: assert property (@(posedge clk) disable iff (!system_reset_out_n)
    enter_overload |=> ctrl_reg.fallback_request && overload_active)
    else $error("overload entry did not set fallback");
  off_clear_a: assert property (@(posedge clk) disable iff (!system_reset_out_n)
    off_entry && !enter_overload && !enter_protect |=> !fallback_out_oe)
    else $error("off entry kept fallback");
  rcc_incr_a: assert property (@(posedge clk) disable iff (!system_reset_out_n)
    sys_reset_evt && !bat_smps_uv && !wr_hit &&
    ctrl_reg.reset_event_counter < FSOC_RCC_MAX |=>
    ctrl_reg.reset_event_counter == $past(ctrl_reg.reset_event_counter) + 1)
    else $error("reset counter did not increment");
  protect_entry_a: assert property (@(posedge clk) disable iff (!system_reset_out_n)
    enter_protect |=> protect_active && ctrl_reg.fallback_request)
    else $error("full counter reset missed protect");
  release_path_a: assert property (@(posedge clk) disable iff (!system_reset_out_n)
    overload_active && ot_release |=> reset_mode_req && system_reset_out_n_oe
    ##1 !overload_active || $past(ot_activate))
    else $error("overload release skipped reset");
  overload_off_a: assert property (@(posedge clk) disable iff (!system_reset_out_n)
    overload_active |-> supplies_off && highvolt_failsafe &&
    system_reset_out_n_oe)
    else $error("overload outputs wrong");
  warn_irq_a: assert property (@(posedge clk) disable iff (!system_reset_out_n)
    $rose(ot_warning) && otw_irq_enable |=> overheat_warning_irq)
    else $error("warning irq missing");
  hv2_static_a: assert property (@(posedge clk) disable iff (!system_reset_out_n)
    lh_cfg_reg[0] && limp_on && cfg_loaded_reg |=> highvolt_pin_2)
    else $error("pin 2 not driven in limp home");

endmodule
`default_nettype wire

/* core/fsoc_pkg.sv */
package fsoc_pkg;

  // register map
  localparam logic [6:0] FSOC_FAILSAFE_CONTROL_ADDR = 7'h02;
  localparam logic [7:0] FSOC_FAILSAFE_CONTROL_RST  = 8'h00;
  localparam logic [1:0] FSOC_RCC_MAX               = 2'h3;

  // aux source select encodings
  localparam logic [1:0] FSOC_SRC_LOW    = 2'h0;
  localparam logic [1:0] FSOC_SRC_ACTIVE = 2'h1;
  localparam logic [1:0] FSOC_SRC_NORMAL = 2'h2;
  localparam logic [1:0] FSOC_SRC_TIMER  = 2'h3;

  // timing: clock and limp-home waveforms
  localparam longint FSOC_CLK_HZ       = 250_000_000;
  localparam longint FSOC_PWM_HZ       = 100;
  localparam longint FSOC_PWM_DUTY_PCT = 10;
  localparam longint FSOC_SQ_MILLIHZ   = 1_250;
  localparam longint FSOC_PWM_PERIOD_CYC = FSOC_CLK_HZ / FSOC_PWM_HZ;
  localparam longint FSOC_PWM_HIGH_CYC   =
    FSOC_PWM_PERIOD_CYC * FSOC_PWM_DUTY_PCT / 100;
  localparam longint FSOC_SQ_HALF_CYC    =
    FSOC_CLK_HZ * 1000 / FSOC_SQ_MILLIHZ / 2;

  // field layout of the fail-safe control register
  typedef struct packed {
    logic [1:0] aux_out_battery_shutdown; // bits 7:6
    logic       aux_out_drive_select;     // bit 5
    logic [1:0] aux_out_source_select;    // bits 4:3
    logic       fallback_request;         // bit 2
    logic [1:0] reset_event_counter;      // bits 1:0
  } fsoc_ctrl_t;

  // device mode reported by the mode controller
  typedef enum logic [4:0] {
    FSOC_MODE_NORMAL  = 5'b00001,
    FSOC_MODE_STANDBY = 5'b00010,
    FSOC_MODE_RESET   = 5'b00100,
    FSOC_MODE_SLEEP   = 5'b01000,
    FSOC_MODE_OFF     = 5'b10000
  } fsoc_mode_t;

  // fail-safe supervisor state
  typedef enum logic [3:0] {
    FSOC_ST_RUN      = 4'b0001,
    FSOC_ST_OVERLOAD = 4'b0010,
    FSOC_ST_RELEASE  = 4'b0100,
    FSOC_ST_PROTECT  = 4'b1000
  } fsoc_state_t;

endpackage

/* verification/fsoc_far_side.sv */
`timescale 1ns/10ps
`default_nettype none
module fsoc_far_side (
  input  wire logic aux_out_o,             // aux level from block
  input  wire logic aux_out_oe,            // aux enable from block
  input  wire logic fallback_out_oe,       // fallback pull-down on
  input  wire logic system_reset_out_n_oe, // reset pull-down on
  output logic      aux_pin,               // resolved aux wire
  output logic      fallback_pin_n,        // resolved fallback wire
  output logic      reset_pin_n            // resolved reset wire
);
  // external pull-ups: a released line reads high, never a stale level
  assign aux_pin        = aux_out_oe ? aux_out_o : 1'h1;
  assign fallback_pin_n = fallback_out_oe ? 1'h0 : 1'h1;
  assign reset_pin_n    = system_reset_out_n_oe ? 1'h0 : 1'h1;
endmodule
`default_nettype wire

/* verification/fsoc_failsafe_output_control_bench.sv */
`timescale 1ns/10ps
`default_nettype none
module fsoc_failsafe_output_control_bench;
  import fsoc_pkg::*;
  logic clk = 1'h0, system_reset_out_n = 1'h0, wr_en = 1'h0, rd_en = 1'h0;
  logic [6:0] addr = 7'h00;
  logic [7:0] wdata = 8'h00, rdata, q;
  fsoc_mode_t mode = FSOC_MODE_NORMAL;
  logic evt = 1'h0, smps_uv = 1'h0, uv = 1'h0, ov = 1'h0, t2 = 1'h0;
  logic ot_act = 1'h0, ot_rel = 1'h0, ot_warn = 1'h0, irq_en = 1'h0;
  logic [2:0] cfg = 3'h7;
  logic aux_o, aux_oe, fb_o, fb_oe, rs_o, rs_oe, hv2, hv3, hv4, hv_fs;
  logic sup_off, ovl, prot, rst_req, irq, aux_pin, fb_pin_n, rst_pin_n;
  int n_errors = 0, total_checks = 0, k;
  fsoc_mode_t mlist [4] = '{FSOC_MODE_NORMAL, FSOC_MODE_STANDBY,
                            FSOC_MODE_RESET, FSOC_MODE_SLEEP};

  fsoc_failsafe_output_control #(.PWM_PERIOD_CYC(20), .PWM_HIGH_CYC(2),
    .SQ_HALF_CYC(10)) dut_u (.clk(clk), .system_reset_out_n(system_reset_out_n), .reg_wr_en(wr_en),
    .reg_rd_en(rd_en), .reg_addr(addr), .reg_wdata(wdata),
    .reg_rdata(rdata), .sbc_mode(mode), .sys_reset_evt(evt),
    .bat_smps_uv(smps_uv), .bat_uv(uv), .bat_ov(ov), .timer2_out(t2),
    .ot_activate(ot_act), .ot_release(ot_rel), .ot_warning(ot_warn),
    .otw_irq_enable(irq_en), .limp_pin_cfg(cfg), .aux_out_o(aux_o),
    .aux_out_oe(aux_oe), .fallback_out_o(fb_o), .fallback_out_oe(fb_oe),
    .system_reset_out_n_o(rs_o), .system_reset_out_n_oe(rs_oe),
    .highvolt_pin_2(hv2), .highvolt_pin_3(hv3), .highvolt_pin_4(hv4),
    .highvolt_failsafe(hv_fs), .supplies_off(sup_off),
    .overload_active(ovl), .protect_active(prot), .reset_mode_req(rst_req),
    .overheat_warning_irq(irq));
  fsoc_far_side far_u (.aux_out_o(aux_o), .aux_out_oe(aux_oe),
    .fallback_out_oe(fb_oe), .system_reset_out_n_oe(rs_oe),
    .aux_pin(aux_pin), .fallback_pin_n(fb_pin_n), .reset_pin_n(rst_pin_n));

  // free-running 250 MHz clock
  always #2 clk = ~clk;

  task automatic final_report();
    if (n_errors == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [7:0] e,
                     input logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // strobes last one cycle and drop on the following edge
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(posedge clk);
    wr_en <= 1'h1;
    addr  <= a;
    wdata <= d;
    @(posedge clk);
    wr_en <= 1'h0;
  endtask

  task automatic rd(input logic [6:0] a, output logic [7:0] d);
    @(posedge clk);
    rd_en <= 1'h1;
    addr  <= a;
    @(posedge clk);
    rd_en <= 1'h0;
    step(1);
    d = rdata;
  endtask

  task automatic pulse_reset();
    @(posedge clk);
    evt <= 1'h1;
    @(posedge clk);
    evt <= 1'h0;
    step(2);
  endtask

  task automatic t_regs();
    rd(7'h02, q);
    chk("reset value", FSOC_FAILSAFE_CONTROL_RST, q);
    wr(7'h03, 8'hff);
    rd(7'h03, q);
    chk("unmapped read", 8'h00, q);
    wr(7'h02, 8'he9);
    rd(7'h02, q);
    chk("readback", 8'he9, q);
  endtask

  // every source code, both drive kinds, four modes
  task automatic t_aux_src();
    logic e;
    for (int d = 0; d < 2; d++) begin
      for (int s = 0; s < 4; s++) begin
        wr(7'h02, {2'h0, d[0], s[1:0], 3'h0});
        for (k = 0; k < 4; k++) begin
          @(posedge clk);
          mode <= mlist[k];
          t2   <= ~k[0];
          step(3);
          e = (s == 1) ? (k < 3) : (s == 2) ? (k == 0) : (s == 3) ? ~k[0]
              : 1'h0;
          chk("aux level", {7'h0, e}, {7'h0, aux_pin});
          chk("aux enable", {7'h0, ~d[0] | ~e}, {7'h0, aux_oe});
        end
      end
    end
  endtask

  // shutdown codes against every battery fault combination
  task automatic t_shutdown();
    for (int sd = 0; sd < 4; sd++) begin
      wr(7'h02, {sd[1:0], 6'h08});
      for (k = 0; k < 4; k++) begin
        @(posedge clk);
        mode <= FSOC_MODE_NORMAL;
        uv   <= k[0];
        ov   <= k[1];
        step(3);
        chk("aux shutdown", {7'h0, ~((sd[0] & k[0]) | (sd[1] & k[1]))},
            {7'h0, aux_pin});
      end
    end
    @(posedge clk);
    mode <= FSOC_MODE_STANDBY;
    step(3);
    chk("aux standby", 8'h01, {7'h0, aux_pin});
    @(posedge clk);
    uv <= 1'h0;
    ov <= 1'h0;
  endtask

  task automatic t_counter();
    wr(7'h02, 8'h00);
    smps_uv <= 1'h1;
    pulse_reset();
    rd(7'h02, q);
    chk("count low supply", 8'h00, q);
    @(posedge clk);
    smps_uv <= 1'h0;
    for (k = 1; k < 4; k++) begin
      pulse_reset();
      rd(7'h02, q);
      chk("count", k[7:0], q);
    end
    pulse_reset();
    rd(7'h02, q);
    chk("count saturate", 8'h07, q);
    chk("protect", 8'h01, {7'h0, prot});
    chk("fallback pin", 8'h00, {7'h0, fb_pin_n});
    @(posedge clk);
    mode <= FSOC_MODE_OFF;
    step(3);
    rd(7'h02, q);
    chk("off clears", 8'h03, q);
    chk("fallback off", 8'h01, {7'h0, fb_pin_n});
    @(posedge clk);
    mode <= FSOC_MODE_NORMAL;
  endtask

  task automatic t_overload();
    int c3, c4, seen;
    c3 = 0;
    c4 = 0;
    seen = 0;
    @(posedge clk);
    ot_act <= 1'h1;
    step(3);
    chk("overload", 8'h01, {7'h0, ovl});
    chk("supplies", 8'h03, {6'h0, sup_off, hv_fs});
    chk("reset pin", 8'h00, {7'h0, rst_pin_n});
    chk("pin levels", 8'h00, {6'h0, fb_o, rs_o});
    chk("fallback set", 8'h00, {7'h0, fb_pin_n});
    chk("pin2 static", 8'h01, {7'h0, hv2});
    // any 20-cycle window holds one full pwm period and two half waves
    repeat (20) begin
      step(1);
      c3 += hv3;
      c4 += hv4;
    end
    chk("pin3 duty", 8'd2, c3[7:0]);
    chk("pin4 duty", 8'd10, c4[7:0]);
    @(posedge clk);
    ot_act <= 1'h0;
    ot_rel <= 1'h1;
    repeat (6) begin
      step(1);
      seen += rst_req;
    end
    @(posedge clk);
    ot_rel <= 1'h0;
    chk("via reset", 8'h01, seen[7:0]);
    chk("left overload", 8'h03, {6'h0, ~ovl, rst_pin_n});
    wr(7'h02, 8'h00);
    step(2);
    chk("host clear", 8'h10, {3'h0, fb_pin_n, 3'h0, hv2});
  endtask

  task automatic t_warning();
    int seen;
    seen = 0;
    for (k = 0; k < 2; k++) begin
      @(posedge clk);
      irq_en  <= k[0];
      ot_warn <= 1'h1;
      repeat (5) begin
        step(1);
        seen += irq;
      end
      @(posedge clk);
      ot_warn <= 1'h0;
      step(3);
      chk("warning irq", {7'h0, k[0]}, seen[7:0]);
      seen = 0;
    end
  endtask

  // mid-run reset, then only pins 2 and 4 picked for limp home;
  // the pin choice is caught once after release, so it needs a reset
  task automatic t_cfg();
    int c3, c4;
    c3 = 0;
    c4 = 0;
    wr(7'h02, 8'h06);
    step(2);
    @(posedge clk);
    system_reset_out_n <= 1'h0;
    cfg  <= 3'h5;
    step(2);
    chk("reset outputs", 8'h00, {5'h0, fb_oe, hv2, rst_req});
    @(posedge clk);
    system_reset_out_n <= 1'h1;
    rd(7'h02, q);
    chk("reset again", FSOC_FAILSAFE_CONTROL_RST, q);
    wr(7'h02, 8'h04);
    step(2);
    chk("pin2 cfg", 8'h01, {7'h0, hv2});
    repeat (20) begin
      step(1);
      c3 += hv3;
      c4 += hv4;
    end
    chk("pin3 cfg off", 8'd0, c3[7:0]);
    chk("pin4 cfg on", 8'd10, c4[7:0]);
    wr(7'h02, 8'h00);
  endtask

  // main sequence: reset held three cycles, then each scenario
  initial begin
    repeat (3) @(posedge clk);
    system_reset_out_n <= 1'h1;
    t_regs();
    t_aux_src();
    t_shutdown();
    t_counter();
    t_overload();
    t_warning();
    t_cfg();
    final_report();
  end

  // watchdog: the scenarios need well under 3000 cycles
  initial begin
    #40000;
    n_errors++;
    final_report();
  end
endmodule
`default_nettype wire
